// ==== hw/lerr_defines.svh ====
// link error routing register bank: offsets, field positions, reset values
// assumes inclusion by bare name from design files
`ifndef LERR_DEFINES_SVH
`define LERR_DEFINES_SVH
// register indices (printed offsets); byte address is four times the index
`define LERR_IDX_CAP 8'h52
`define LERR_IDX_SCRATCH 8'h54
`define LERR_IDX_ERRCTL 8'h56
`define LERR_IDX_MEMUP 8'h58
`define LERR_IDX_LINK0_ERR 8'h60
`define LERR_IDX_LINK1_ERR 8'h61
`define LERR_IDX_IRQ_STAT 8'h62
`define LERR_IDX_IRQ_MASK 8'h63
`define LERR_IDX_MODE 8'h64
// error routing field positions
`define LERR_B_SYS_NF 15
`define LERR_B_CRC_NF 14
`define LERR_B_RSP_NF 13
`define LERR_B_EOC_NF 12
`define LERR_B_OVF_NF 11
`define LERR_B_PROT_NF 10
`define LERR_B_RSP_ERR 9
`define LERR_B_CHAIN_FAIL 8
`define LERR_B_SYS_F 7
`define LERR_B_CRC_F 6
`define LERR_B_RSP_F 5
`define LERR_B_EOC_F 4
`define LERR_B_OVF_F 3
`define LERR_B_PROT_F 2
`define LERR_B_OVF_FLOOD 1
`define LERR_B_PROT_FLOOD 0
// link error register flag positions
`define LERR_B_L_EOC 6
`define LERR_B_L_OVF 5
`define LERR_B_L_PROT 4
// writable enables of the error routing register
`define LERR_ERRCTL_WMASK 16'h7c7f
// capability masks by core clock
`define LERR_CAP_100 16'h0007
`define LERR_CAP_133 16'h000f
`define LERR_CAP_200 16'h001f
`define LERR_SCRATCH_RST 16'h0000
`define LERR_AXI_OKAY 2'b00
`define LERR_AXI_SLVERR 2'b10
`endif

// ==== hw/lerr_pkg.sv ====
// link error routing package: operating modes and core clock classes
// assumes lerr_defines.svh carries all numbers
package lerr_pkg;
  typedef enum logic [1:0] {
    LERR_MODE_SINGLE = 2'b00,
    LERR_MODE_DUAL = 2'b01,
    LERR_MODE_REDUCED_SINGLE = 2'b11,
    LERR_MODE_REDUCED_DUAL = 2'b10
  } lerr_mode_t;
  typedef enum logic [1:0] {
    LERR_CORE_100 = 2'b00,
    LERR_CORE_133 = 2'b01,
    LERR_CORE_200 = 2'b10
  } lerr_core_t;
endpackage : lerr_pkg

// ==== hw/lerr_regs.sv ====
// link error routing register bank behind an axi4-lite slave
// assumes error event pulses come from logic on clk; strap pins are synchronised here
// Operation
// - link rate capability mask is sixteen read-only bits, one per encoding
// - mask is 0x0007, 0x000f or 0x001f for 100, 133, 200 MHz core
// - dual mode: each space's link-0 register; single mode: first space's link-1 register
// - in reduced modes capability registers read zero
// - sixteen-bit scratchpad resets to zero and steers nothing
// - system-error enables bits 15 and 7 hardwired to zero
// - bit 14 routes any crc error to the nonfatal interrupt
// - bit 13 routes the response error flag to the nonfatal interrupt
// - bits 12..10 route end-of-chain, overflow, protocol errors to nonfatal
// - bits 6..2 route crc, response, eoc, overflow, protocol to fatal
// - bits 1 and 0 flood sync on overflow or protocol error
// - response error flag set by event, cleared by read, kept over warm reset
// - chain fail set on flooding, cleared only by system, chain or warm reset
// - all enables reset to zero and clear on warm reset
// - upper memory base and limit bytes read zero
// - each link error register holds read-to-clear eoc, overflow, protocol flags
// - rate encodings 0000..0100 valid; mask bits index these encodings
`timescale 1ns/1ns
`default_nettype none
`include "lerr_defines.svh"
module lerr_regs
  import lerr_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic warm_rst,
  input wire logic chain_rst,
  input wire logic [1:0] core_clk_sel,
  input wire logic [1:0] mode_sel,
  input wire logic [1:0] crc_err,
  input wire logic rsp_err_evt,
  input wire logic [1:0] eoc_evt,
  input wire logic [1:0] ovf_evt,
  input wire logic [1:0] prot_evt,
  input wire logic sync_flood_seen,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic fatal_err_n,
  output logic nonfatal_err_n,
  output logic sync_flood,
  output logic irq
);
  if (ADDR_W < 10) $error("lerr_regs: ADDR_W must be at least 10");
  // strap synchronisers
  logic [1:0] core_s1, core_s2, mode_s1, mode_s2;
  lerr_mode_t mode;
  lerr_core_t core;
  always_ff @(posedge clk)
  begin
    core_s1 <= core_clk_sel;
    core_s2 <= core_s1;
    mode_s1 <= mode_sel;
    mode_s2 <= mode_s1;
  end
  assign mode = lerr_mode_t'(mode_s2);
  assign core = lerr_core_t'(core_s2);
  logic reduced;
  assign reduced = mode[1];
  // capability mask
  logic [15:0] cap_val;
  always_comb
  begin
    unique case (core)
      LERR_CORE_100: cap_val = `LERR_CAP_100;
      LERR_CORE_133: cap_val = `LERR_CAP_133;
      default: cap_val = `LERR_CAP_200;
    endcase
  end
  // axi write channel capture
  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held <= 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end
  logic [7:0] wr_idx, rd_idx;
  logic wr_word_ok, rd_word_ok;
  assign wr_idx = aw_addr[9:2];
  assign rd_idx = s_axi_araddr[9:2];
  assign wr_word_ok = (aw_addr[ADDR_W-1:10] == '0);
  assign rd_word_ok = (s_axi_araddr[ADDR_W-1:10] == '0);
  logic [15:0] wmask16;
  assign wmask16 = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = idx == `LERR_IDX_CAP || idx == `LERR_IDX_SCRATCH ||
      idx == `LERR_IDX_ERRCTL || idx == `LERR_IDX_MEMUP ||
      idx == `LERR_IDX_LINK0_ERR || idx == `LERR_IDX_LINK1_ERR ||
      idx == `LERR_IDX_IRQ_STAT || idx == `LERR_IDX_IRQ_MASK ||
      idx == `LERR_IDX_MODE;
  endfunction : idx_mapped
  logic wr_scratch, wr_errctl, wr_stat, wr_mask;
  assign wr_scratch = wr_go && wr_word_ok && wr_idx == `LERR_IDX_SCRATCH && !reduced;
  assign wr_errctl = wr_go && wr_word_ok && wr_idx == `LERR_IDX_ERRCTL && !reduced;
  assign wr_stat = wr_go && wr_word_ok && wr_idx == `LERR_IDX_IRQ_STAT;
  assign wr_mask = wr_go && wr_word_ok && wr_idx == `LERR_IDX_IRQ_MASK;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LERR_AXI_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_word_ok && idx_mapped(wr_idx)) ? `LERR_AXI_OKAY : `LERR_AXI_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
  // read channel: one cycle answer
  logic rd_go;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_axi_arready <= 1'b0;
    else
      s_axi_arready <= !s_axi_rvalid && !rd_go;
  end
  // scratchpad
  logic [15:0] scratch;
  always_ff @(posedge clk)
  begin
    if (sys_rst || warm_rst)
      scratch <= `LERR_SCRATCH_RST;
    else if (wr_scratch)
      scratch <= (scratch & ~wmask16) | (w_data[15:0] & wmask16);
  end
  // routing enables, writable bits only
  logic [15:0] en;
  always_ff @(posedge clk)
  begin
    if (sys_rst || warm_rst)
      en <= 16'h0000;
    else if (wr_errctl)
      en <= (en & ~wmask16) | (w_data[15:0] & wmask16 & `LERR_ERRCTL_WMASK);
  end
  // read-to-clear side effects
  logic rd_errctl, rd_l0, rd_l1;
  assign rd_errctl = rd_go && rd_word_ok && rd_idx == `LERR_IDX_ERRCTL && !reduced;
  assign rd_l0 = rd_go && rd_word_ok && rd_idx == `LERR_IDX_LINK0_ERR;
  assign rd_l1 = rd_go && rd_word_ok && rd_idx == `LERR_IDX_LINK1_ERR;
  // response error flag survives warm reset; a new event wins over the read
  logic rsp_err;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rsp_err <= 1'b0;
    else if (rsp_err_evt)
      rsp_err <= 1'b1;
    else if (rd_errctl)
      rsp_err <= 1'b0;
  end
  // link error flags {eoc, ovf, prot} per link, persistent through warm reset
  logic [1:0] l_eoc, l_ovf, l_prot;
  logic [1:0] rd_link;
  assign rd_link = {rd_l1, rd_l0};
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      l_eoc <= 2'b00;
      l_ovf <= 2'b00;
      l_prot <= 2'b00;
    end
    else
    begin
      l_eoc <= eoc_evt | (l_eoc & ~rd_link);
      l_ovf <= ovf_evt | (l_ovf & ~rd_link);
      l_prot <= prot_evt | (l_prot & ~rd_link);
    end
  end
  // routing
  logic any_crc, any_eoc, any_ovf, any_prot;
  assign any_crc = |crc_err;
  assign any_eoc = |l_eoc;
  assign any_ovf = |l_ovf;
  assign any_prot = |l_prot;
  logic nf_src, f_src, flood_src;
  assign nf_src = (en[`LERR_B_CRC_NF] && any_crc)
    || (en[`LERR_B_RSP_NF] && rsp_err)
    || (en[`LERR_B_EOC_NF] && any_eoc) || (en[`LERR_B_OVF_NF] && any_ovf)
    || (en[`LERR_B_PROT_NF] && any_prot);
  assign f_src = (en[`LERR_B_CRC_F] && any_crc) || (en[`LERR_B_RSP_F] && rsp_err)
    || (en[`LERR_B_EOC_F] && any_eoc) || (en[`LERR_B_OVF_F] && any_ovf)
    || (en[`LERR_B_PROT_F] && any_prot);
  assign flood_src = (en[`LERR_B_OVF_FLOOD] && any_ovf)
    || (en[`LERR_B_PROT_FLOOD] && any_prot);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fatal_err_n <= 1'b1;
      nonfatal_err_n <= 1'b1;
      sync_flood <= 1'b0;
    end
    else
    begin
      fatal_err_n <= !f_src;
      nonfatal_err_n <= !nf_src;
      sync_flood <= flood_src;
    end
  end
  // chain fail
  logic chain_fail;
  always_ff @(posedge clk)
  begin
    if (sys_rst || warm_rst || chain_rst)
      chain_fail <= 1'b0;
    else if (sync_flood_seen || flood_src)
      chain_fail <= 1'b1;
  end
  // interrupt status: bit0 fatal, bit1 nonfatal, bit2 flood, bit3 response error
  logic [3:0] ev, istat, imask, next_istat;
  assign ev = {rsp_err_evt, flood_src, nf_src, f_src};
  // a new event wins over the write-one-to-clear
  assign next_istat = ev | (istat & ~(wr_stat ? w_data[3:0] & {4{w_strb[0]}} : 4'h0));
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      istat <= 4'h0;
    else
      istat <= next_istat;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      imask <= 4'h0;
    else if (wr_mask && w_strb[0])
      imask <= w_data[3:0];
  end
  // a set mask bit keeps its status bit off the interrupt
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(next_istat & ~imask);
  end
  // read mux
  logic [15:0] errctl_rd, cap_rd;
  assign errctl_rd = (en & `LERR_ERRCTL_WMASK) | (16'(rsp_err) << `LERR_B_RSP_ERR)
    | (16'(chain_fail) << `LERR_B_CHAIN_FAIL);
  assign cap_rd = reduced ? 16'h0000 : cap_val;
  logic [15:0] rd_val;
  always_comb
  begin
    rd_val = 16'h0000;
    if (rd_word_ok)
    begin
      unique case (rd_idx)
        `LERR_IDX_CAP: rd_val = cap_rd;
        `LERR_IDX_SCRATCH: rd_val = reduced ? 16'h0000 : scratch;
        `LERR_IDX_ERRCTL: rd_val = reduced ? 16'h0000 : errctl_rd;
        `LERR_IDX_MEMUP: rd_val = 16'h0000;
        `LERR_IDX_LINK0_ERR: rd_val = {9'h0, l_eoc[0], l_ovf[0], l_prot[0], 4'h0};
        `LERR_IDX_LINK1_ERR: rd_val = {9'h0, l_eoc[1], l_ovf[1], l_prot[1], 4'h0};
        `LERR_IDX_IRQ_STAT: rd_val = {12'h0, istat};
        `LERR_IDX_IRQ_MASK: rd_val = {12'h0, imask};
        `LERR_IDX_MODE: rd_val = {12'h0, core_s2, mode_s2};
        default: rd_val = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `LERR_AXI_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0, rd_val};
      s_axi_rresp <= (rd_word_ok && idx_mapped(rd_idx)) ? `LERR_AXI_OKAY : `LERR_AXI_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  // assertions
  property p_cap_reduced;
    @(posedge clk) disable iff (sys_rst)
    (rd_go && rd_word_ok && rd_idx == `LERR_IDX_CAP && reduced) |=> s_axi_rdata == 32'h0;
  endproperty
  a_cap_reduced: assert property (p_cap_reduced) else $error("cap not zero in reduced mode");
  property p_cap_100;
    @(posedge clk) disable iff (sys_rst)
    (rd_go && rd_idx == `LERR_IDX_CAP && rd_word_ok && !reduced && core == LERR_CORE_100)
      |=> s_axi_rdata[15:0] == 16'h0007;
  endproperty
  a_cap_100: assert property (p_cap_100) else $error("cap mask wrong at 100 MHz");
  property p_sys_en_zero;
    @(posedge clk) disable iff (sys_rst)
    en[`LERR_B_SYS_NF] == 1'b0 && en[`LERR_B_SYS_F] == 1'b0;
  endproperty
  a_sys_en_zero: assert property (p_sys_en_zero) else $error("system enables not zero");
  property p_nonfatal;
    @(posedge clk) disable iff (sys_rst)
    (en[`LERR_B_RSP_NF] && rsp_err) |=> !nonfatal_err_n;
  endproperty
  a_nonfatal: assert property (p_nonfatal) else $error("nonfatal missing");
  property p_fatal;
    @(posedge clk) disable iff (sys_rst)
    (en[`LERR_B_OVF_F] && any_ovf) |=> !fatal_err_n;
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal missing");
  property p_flood;
    @(posedge clk) disable iff (sys_rst)
    (en[`LERR_B_PROT_FLOOD] && any_prot) |=> sync_flood ##1 chain_fail || $past(warm_rst);
  endproperty
  a_flood: assert property (p_flood) else $error("flood or chain fail missing");
  property p_rsp_keep;
    @(posedge clk) disable iff (sys_rst)
    (rsp_err && warm_rst && !rd_errctl) |=> rsp_err;
  endproperty
  a_rsp_keep: assert property (p_rsp_keep) else $error("response error lost on warm reset");
  property p_warm_en;
    @(posedge clk) disable iff (sys_rst)
    warm_rst |=> en == 16'h0 && !chain_fail;
  endproperty
  a_warm_en: assert property (p_warm_en) else $error("warm reset left enables");
  property p_memup;
    @(posedge clk) disable iff (sys_rst)
    (rd_go && rd_word_ok && rd_idx == `LERR_IDX_MEMUP) |=> s_axi_rdata == 32'h0;
  endproperty
  a_memup: assert property (p_memup) else $error("upper memory bytes not zero");
  c_nonfatal: cover property (@(posedge clk) disable iff (sys_rst) $fell(nonfatal_err_n));
  c_fatal: cover property (@(posedge clk) disable iff (sys_rst) $fell(fatal_err_n));
  c_flood: cover property (@(posedge clk) disable iff (sys_rst) $rose(sync_flood));
  c_rd_clear: cover property (@(posedge clk) disable iff (sys_rst) rsp_err && rd_errctl);
endmodule : lerr_regs
`default_nettype wire

// ==== tb/lerr_link_src.sv ====
// link event source standing in for the packet link chain
// assumes go is a one-cycle strobe from the bench, launched on clk
`timescale 1ns/1ns
`default_nettype none
module lerr_link_src (
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic lnk,
  input wire logic crc_on,
  output logic [1:0] crc_err,
  output logic rsp_err_evt,
  output logic [1:0] eoc_evt,
  output logic [1:0] ovf_evt,
  output logic [1:0] prot_evt,
  output logic sync_flood_seen
);
  logic [1:0] sel;
  assign sel = go ? (lnk ? 2'b10 : 2'b01) : 2'b00;
  // crc flag is a level held by link control
  assign crc_err = crc_on ? (lnk ? 2'b10 : 2'b01) : 2'b00;
  assign rsp_err_evt = go && kind == 3'd1;
  assign eoc_evt = kind == 3'd2 ? sel : 2'b00;
  assign ovf_evt = kind == 3'd3 ? sel : 2'b00;
  assign prot_evt = kind == 3'd4 ? sel : 2'b00;
  assign sync_flood_seen = go && kind == 3'd5;
endmodule : lerr_link_src
`default_nettype wire

// ==== tb/test_link_error_routing_regs.sv ====
// self-checking bench for the link error routing register bank
// assumes lerr_regs and lerr_link_src are compiled before it
`timescale 1ns/1ns
`default_nettype none
`include "lerr_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_link_error_routing_regs
  import lerr_pkg::*;
;
  logic clk, sys_rst, warm_rst, chain_rst, go, lnk, crc_on, rsp_err_evt, flood_seen;
  logic [1:0] core_sel, mode, crc_err, eoc_evt, ovf_evt, prot_evt, bresp, rresp, rr;
  logic [2:0] kind;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [15:0] cap, en;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic fatal_n, nonfatal_n, sync_flood, irq;
  int num_errors, samples_checked;
  lerr_regs dut (.clk(clk), .sys_rst(sys_rst), .warm_rst(warm_rst), .chain_rst(chain_rst),
    .core_clk_sel(core_sel), .mode_sel(mode), .crc_err(crc_err), .rsp_err_evt(rsp_err_evt),
    .eoc_evt(eoc_evt), .ovf_evt(ovf_evt), .prot_evt(prot_evt), .sync_flood_seen(flood_seen),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fatal_err_n(fatal_n), .nonfatal_err_n(nonfatal_n), .sync_flood(sync_flood), .irq(irq));
  lerr_link_src link (.go(go), .kind(kind), .lnk(lnk), .crc_on(crc_on), .crc_err(crc_err),
    .rsp_err_evt(rsp_err_evt), .eoc_evt(eoc_evt), .ovf_evt(ovf_evt), .prot_evt(prot_evt),
    .sync_flood_seen(flood_seen));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ba
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic hang;
    num_errors++;
    $display("[FAIL] %0t bus timeout", $time);
    test_done;
  endtask : hang
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (n > 50)
        hang;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    do
    begin
      @(posedge clk);
      n++;
      if (n > 50)
        hang;
    end
    while (!bvalid);
    `CHK(bresp, `LERR_AXI_OKAY)
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 50)
        hang;
    end
    while (!arready);
    arvalid <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 50)
        hang;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [7:0] i, input logic [31:0] e);
    rd(ba(i), rd_v, rr);
    `CHK(rd_v, e)
    `CHK(rr, `LERR_AXI_OKAY)
  endtask : rdc
  task automatic rd_bit(input logic [7:0] i, input int b);
    rd(ba(i), rd_v, rr);
    `CHK(rd_v[b], 1'b1)
  endtask : rd_bit
  task automatic fire(input logic [2:0] k, input logic l);
    @(posedge clk);
    kind <= k;
    lnk <= l;
    if (k == 3'd0)
      crc_on <= 1'b1;
    else
      go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : fire
  task automatic outs(input logic f, input logic nf, input logic fl);
    tick(3);
    `CHK(fatal_n, f)
    `CHK(nonfatal_n, nf)
    `CHK(sync_flood, fl)
  endtask : outs
  initial
  begin
    sys_rst = 1'b1;
    warm_rst = 1'b0;
    chain_rst = 1'b0;
    go = 1'b0;
    kind = 3'd0;
    lnk = 1'b0;
    crc_on = 1'b0;
    core_sel = LERR_CORE_100;
    mode = LERR_MODE_SINGLE;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    tick(2);
    sys_rst <= 1'b0;
    outs(1'b1, 1'b1, 1'b0);
    `CHK(irq, 1'b0)
    rdc(`LERR_IDX_MEMUP, 32'h0);
    rdc(`LERR_IDX_SCRATCH, 32'h0);
    rdc(`LERR_IDX_ERRCTL, 32'h0);
    for (int c = 0; c < 6; c++)
    begin
      core_sel <= c[1:0];
      mode <= c < 4 ? {1'b0, c[0]} : {1'b1, c[0]};
      tick(4);
      cap = c == 0 ? `LERR_CAP_100 : c == 1 ? `LERR_CAP_133 : `LERR_CAP_200;
      rdc(`LERR_IDX_CAP, c < 4 ? {16'h0, cap} : 32'h0);
      if (c >= 4)
        wr(ba(`LERR_IDX_SCRATCH), 32'h0000_5a5a);
    end
    mode <= LERR_MODE_SINGLE;
    tick(4);
    rdc(`LERR_IDX_MODE, 32'h0000_0004);
    rdc(`LERR_IDX_SCRATCH, 32'h0);
    wr(ba(`LERR_IDX_SCRATCH), 32'hffff_a5c3);
    rdc(`LERR_IDX_SCRATCH, 32'h0000_a5c3);
    outs(1'b1, 1'b1, 1'b0);
    wr(ba(`LERR_IDX_ERRCTL), 32'h0000_ffff);
    rdc(`LERR_IDX_ERRCTL, {16'h0, `LERR_ERRCTL_WMASK});
    for (int m = 0; m < 3; m++)
      for (int k = 0; k < 5; k++)
      begin
        if (m < 2 || k > 2)
        begin
          en = m == 0 ? 16'h4000 >> k : m == 1 ? 16'h0040 >> k : 16'h0010 >> k;
          wr(ba(`LERR_IDX_ERRCTL), {16'h0, en});
          fire(k[2:0], k[0]);
          outs(m != 1, m != 0, m == 2);
          if (k == 0)
            crc_on <= 1'b0;
          else if (k == 1)
            rd_bit(`LERR_IDX_ERRCTL, 9);
          else
            rd_bit(k[0] ? `LERR_IDX_LINK1_ERR : `LERR_IDX_LINK0_ERR, 8 - k);
          outs(1'b1, 1'b1, 1'b0);
        end
      end
    rd_bit(`LERR_IDX_ERRCTL, 8);
    chain_rst <= 1'b1;
    tick(1);
    chain_rst <= 1'b0;
    rdc(`LERR_IDX_ERRCTL, 32'h0000_0001);
    fire(3'd5, 1'b0);
    rd_bit(`LERR_IDX_ERRCTL, 8);
    wr(ba(`LERR_IDX_SCRATCH), 32'h0000_1234);
    wr(ba(`LERR_IDX_ERRCTL), 32'h0000_7c7f);
    fire(3'd1, 1'b0);
    outs(1'b0, 1'b0, 1'b0);
    warm_rst <= 1'b1;
    tick(1);
    warm_rst <= 1'b0;
    outs(1'b1, 1'b1, 1'b0);
    rdc(`LERR_IDX_ERRCTL, 32'h0000_0200);
    rdc(`LERR_IDX_ERRCTL, 32'h0);
    rdc(`LERR_IDX_SCRATCH, 32'h0);
    wr(ba(`LERR_IDX_IRQ_STAT), 32'h0000_000f);
    wr(ba(`LERR_IDX_IRQ_MASK), 32'h0);
    tick(3);
    `CHK(irq, 1'b0)
    wr(ba(`LERR_IDX_ERRCTL), 32'h0000_0004);
    fire(3'd4, 1'b1);
    outs(1'b0, 1'b1, 1'b0);
    `CHK(irq, 1'b1)
    rdc(`LERR_IDX_IRQ_STAT, 32'h0000_0001);
    wr(ba(`LERR_IDX_IRQ_MASK), 32'h0000_000f);
    tick(3);
    `CHK(irq, 1'b0)
    rd_bit(`LERR_IDX_LINK1_ERR, 4);
    wr(ba(`LERR_IDX_IRQ_STAT), 32'h0000_000f);
    wr(ba(`LERR_IDX_IRQ_MASK), 32'h0);
    tick(3);
    `CHK(irq, 1'b0)
    rd(ba(8'h70), rd_v, rr);
    `CHK(rr, `LERR_AXI_SLVERR)
    `CHK(rd_v, 32'h0)
    test_done;
  end
endmodule : test_link_error_routing_regs
`default_nettype wire
